// File: pfc_params.svh
// constants for the pin function control block
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH
`define PFC_ALE_PERIOD 6
`define PFC_RST_PULSE_CYC 24
`define PFC_CR_REF_DIR 5
`define PFC_CR_CAN_RESET 0
`define PFC_LATCH_RESET 8'hFF
`define PFC_INT_ROM_TOP 16'h7FFF
`define PFC_P1_T2_EVENT 4
`define PFC_P1_T2_CLEAR 5
`define PFC_P1_CTX_A 6
`define PFC_P1_CTX_B 7
`define PFC_P3_TXD 1
`define PFC_P3_WR 6
`define PFC_P3_RD 7
`endif

// File: pfc_pkg.sv
// types shared by the pin function control block
package pfc_pkg;
    typedef logic [7:0] pfc_byte_t;
    typedef enum logic {PFC_RST_IDLE, PFC_RST_DRIVE} pfc_rst_e;
endpackage

// File: pfc_qport_if.sv
// one 8-bit port between the control logic and its pin slice
`timescale 1ns/1ns
interface pfc_qport_if;
    pfc_pkg::pfc_byte_t latch;
    pfc_pkg::pfc_byte_t alt_out;
    pfc_pkg::pfc_byte_t force_en;
    pfc_pkg::pfc_byte_t force_val;
    pfc_pkg::pfc_byte_t od;
    pfc_pkg::pfc_byte_t pin_i;
    pfc_pkg::pfc_byte_t pin_o;
    pfc_pkg::pfc_byte_t pin_oe;
    pfc_pkg::pfc_byte_t pin_pu;
    pfc_pkg::pfc_byte_t pin_s;
    modport port (input latch, alt_out, force_en, force_val, od, pin_i,
        output pin_o, pin_oe, pin_pu, pin_s);
    modport ctrl (output latch, alt_out, force_en, force_val, od, pin_i,
        input pin_o, pin_oe, pin_pu, pin_s);
endinterface

// File: pfc_qport.sv
// pin slice of one 8-bit port: synchroniser and pad drive
`timescale 1ns/1ns
module pfc_qport (
    input wire logic clk,
    input wire logic srst,
    pfc_qport_if.port pio
);
    pfc_pkg::pfc_byte_t s1_r;
    pfc_pkg::pfc_byte_t s2_r;
    pfc_pkg::pfc_byte_t o_r;
    pfc_pkg::pfc_byte_t oe_r;
    pfc_pkg::pfc_byte_t pu_r;

    // ==========================================
    // input synchroniser
    always_ff @(posedge clk) begin
        s1_r <= pio.pin_i;
        s2_r <= s1_r;
    end
    assign pio.pin_s = s2_r;

    // ==========================================
    // drive per pin
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            logic drv;
            // alternate output only shows while the latch bit is high
            assign drv = pio.force_en[i] ? pio.force_val[i]
                : (pio.latch[i] & pio.alt_out[i]);
            always_ff @(posedge clk) begin
                if (srst) begin
                    o_r[i] <= 1'b1;
                    oe_r[i] <= 1'b0;
                    pu_r[i] <= 1'b0;
                end else begin
                    o_r[i] <= drv;
                    // unforced pins: strong low, weak high (none if open drain) so a high pin can be read back; forced pins drive both levels strong
                    oe_r[i] <= pio.force_en[i] | ~drv;
                    pu_r[i] <= ~pio.force_en[i] & drv & ~pio.od[i];
                end
            end
        end
    endgenerate
    assign pio.pin_o = o_r;
    assign pio.pin_oe = oe_r;
    assign pio.pin_pu = pu_r;
endmodule

// File: pfc_top.sv
// pin function control: port muxing, bus strobes and special pins
`timescale 1ns/1ns
`include "pfc_params.svh"
module pfc_top #(
    parameter int ALE_PERIOD = `PFC_ALE_PERIOD,
    parameter int RST_PULSE_CYC = `PFC_RST_PULSE_CYC
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [7:0] P0_I,
    output logic [7:0] P0_O,
    output logic [7:0] P0_OE,
    input wire logic [7:0] P1_I,
    output logic [7:0] P1_O,
    output logic [7:0] P1_OE,
    output logic [7:0] P1_PU,
    input wire logic [7:0] P2_I,
    output logic [7:0] P2_O,
    output logic [7:0] P2_OE,
    output logic [7:0] P2_PU,
    input wire logic [7:0] P3_I,
    output logic [7:0] P3_O,
    output logic [7:0] P3_OE,
    output logic [7:0] P3_PU,
    input wire logic [7:0] P4_I,
    output logic [7:0] P4_O,
    output logic [7:0] P4_OE,
    output logic [7:0] P4_PU,
    input wire logic [7:0] P5_I,
    input wire logic [4:0] SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [2:0] PORT_RD_SEL,
    output logic [7:0] PORT_RD_DATA,
    input wire logic CONVERSION_START_PIN,
    input wire logic ADC_SW_START,
    output logic ADC_START,
    output logic [7:0] ADC_CHANNEL_IN,
    input wire logic WDT_OVERFLOW,
    input wire logic CAN_WAKEUP,
    output logic RST_PIN_O,
    output logic RST_PIN_OE,
    input wire logic XDATA_ACCESS,
    output logic ALE,
    input wire logic EXTERNAL_ACCESS_SELECT,
    input wire logic [15:0] FETCH_ADDR,
    input wire logic FETCH_REQ,
    output logic FETCH_EXTERNAL,
    output logic PROGRAM_STORE_STROBE_N,
    input wire logic CAN_CTRL_WR,
    input wire logic [7:0] CAN_CTRL_WDATA,
    input wire logic POWER_DOWN,
    output logic REF_PIN_OE,
    output logic REF_SOURCE_EN,
    input wire logic CAN_RECEIVE_POSITIVE,
    input wire logic CAN_RECEIVE_NEGATIVE,
    output logic CAN_RX_BIT,
    input wire logic CAN_TRANSMIT_OUT_A,
    input wire logic CAN_TRANSMIT_OUT_B,
    output logic CAN_IN_RESET,
    output logic TIMER2_EVENT,
    output logic TIMER2_CLEAR,
    output logic [3:0] CAPTURE_INPUT,
    output logic [3:0] EXTRA_INTERRUPT_IN,
    input wire logic [5:0] COMPARE_SETRESET_OUT,
    input wire logic [1:0] COMPARE_TOGGLE_OUT,
    output logic SERIAL_RX_IN,
    input wire logic SERIAL_TX_OUT,
    output logic EXTERNAL_INTERRUPT_ZERO,
    output logic EXTERNAL_INTERRUPT_ONE,
    output logic TIMER0_COUNT_INPUT,
    output logic TIMER1_COUNT_INPUT,
    input wire logic XDATA_WRITE_STROBE_N,
    input wire logic XDATA_READ_STROBE_N,
    input wire logic XBUS_ACTIVE,
    input wire logic XBUS_LOW_DRIVE,
    input wire logic XBUS_ADDR_PHASE,
    input wire logic [15:0] XBUS_ADDR,
    input wire logic [7:0] XBUS_WDATA
);
    pfc_qport_if pif[5] ();
    pfc_pkg::pfc_byte_t latch_r [5];
    pfc_pkg::pfc_byte_t p5_s1_r;
    pfc_pkg::pfc_byte_t p5_s2_r;
    logic [3:0] misc_s1_r;
    logic [3:0] misc_s2_r;
    logic conversion_start_pin_prev_r;
    logic adc_start_r;
    logic [7:0] rd_r;
    logic ea_latched_r;
    logic fetch_ext_r;
    logic program_store_strobe_n_r;
    logic ref_out_r;
    logic can_reset_r;
    logic src_en_r;
    logic rx_r;
    logic [1:0] t2_prev_r;
    logic t2_event_r;
    logic t2_clear_r;
    logic [$clog2(ALE_PERIOD)-1:0] ale_cnt_r;
    logic skip_r;
    logic ale_r;
    pfc_pkg::pfc_rst_e rst_state_r;
    logic [$clog2(RST_PULSE_CYC+1)-1:0] rst_cnt_r;
    logic conversion_start_pin_s;
    logic rxp_s;
    logic rxn_s;
    logic ale_slot;
    logic fetch_ext_nxt;

    // ==========================================
    // pin slices
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_port
            pfc_qport u_port (
                .clk(MCLK),
                .srst(SRST),
                .pio(pif[g])
            );
            assign pif[g].latch = latch_r[g];
        end
    endgenerate

    assign pif[0].pin_i = P0_I;
    assign pif[1].pin_i = P1_I;
    assign pif[2].pin_i = P2_I;
    assign pif[3].pin_i = P3_I;
    assign pif[4].pin_i = P4_I;
    assign P0_O = pif[0].pin_o;
    assign P0_OE = pif[0].pin_oe;
    assign P1_O = pif[1].pin_o;
    assign P1_OE = pif[1].pin_oe;
    assign P1_PU = pif[1].pin_pu;
    assign P2_O = pif[2].pin_o;
    assign P2_OE = pif[2].pin_oe;
    assign P2_PU = pif[2].pin_pu;
    assign P3_O = pif[3].pin_o;
    assign P3_OE = pif[3].pin_oe;
    assign P3_PU = pif[3].pin_pu;
    assign P4_O = pif[4].pin_o;
    assign P4_OE = pif[4].pin_oe;
    assign P4_PU = pif[4].pin_pu;

    // ==========================================
    // port latches, all high after reset
    always_ff @(posedge MCLK) begin
        for (int k = 0; k < 5; k++) begin
            if (SRST) begin
                latch_r[k] <= `PFC_LATCH_RESET;
            end else if (SFR_WR[k]) begin
                latch_r[k] <= SFR_WDATA;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rd_r <= 8'h00;
        end else begin
            case (PORT_RD_SEL)
                3'h0: rd_r <= pif[0].pin_s;
                3'h1: rd_r <= pif[1].pin_s;
                3'h2: rd_r <= pif[2].pin_s;
                3'h3: rd_r <= pif[3].pin_s;
                3'h4: rd_r <= pif[4].pin_s;
                3'h5: rd_r <= p5_s2_r;
                default: rd_r <= 8'h00;
            endcase
        end
    end
    assign PORT_RD_DATA = rd_r;

    // ==========================================
    // port 0: open drain, low address and data while the bus owns it
    assign pif[0].od = 8'hFF;
    assign pif[0].alt_out = 8'hFF;
    assign pif[0].force_en = {8{XBUS_ACTIVE & XBUS_LOW_DRIVE}};
    assign pif[0].force_val = XBUS_ADDR_PHASE ? XBUS_ADDR[7:0] : XBUS_WDATA;

    // ==========================================
    // port 2: high address byte
    assign pif[2].od = 8'h00;
    assign pif[2].alt_out = 8'hFF;
    assign pif[2].force_en = {8{XBUS_ACTIVE}};
    assign pif[2].force_val = XBUS_ADDR[15:8];

    // ==========================================
    // port 3: serial, interrupts, timers, data strobes
    always_comb begin
        pif[3].alt_out = 8'hFF;
        pif[3].alt_out[`PFC_P3_TXD] = SERIAL_TX_OUT;
        pif[3].alt_out[`PFC_P3_WR] = XDATA_WRITE_STROBE_N;
        pif[3].alt_out[`PFC_P3_RD] = XDATA_READ_STROBE_N;
    end
    assign pif[3].od = 8'h00;
    assign pif[3].force_en = 8'h00;
    assign pif[3].force_val = 8'h00;
    assign SERIAL_RX_IN = pif[3].pin_s[0];
    assign EXTERNAL_INTERRUPT_ZERO = pif[3].pin_s[2];
    assign EXTERNAL_INTERRUPT_ONE = pif[3].pin_s[3];
    assign TIMER0_COUNT_INPUT = pif[3].pin_s[4];
    assign TIMER1_COUNT_INPUT = pif[3].pin_s[5];

    // ==========================================
    // port 4: timer-2 compare outputs
    assign pif[4].alt_out = {COMPARE_TOGGLE_OUT, COMPARE_SETRESET_OUT};
    assign pif[4].od = 8'h00;
    assign pif[4].force_en = 8'h00;
    assign pif[4].force_val = 8'h00;

    // ==========================================
    // port 1: capture/interrupt, timer-2 inputs, CAN transmitter
    assign pif[1].alt_out = 8'hFF;
    // in CAN reset the transmitter floats and the two pins act as open drain
    assign pif[1].od = {{2{can_reset_r}}, 6'h00};
    assign pif[1].force_en = {{2{~can_reset_r}}, 6'h00};
    assign pif[1].force_val = {CAN_TRANSMIT_OUT_B, CAN_TRANSMIT_OUT_A, 6'h00};
    assign CAPTURE_INPUT = pif[1].pin_s[3:0];
    assign EXTRA_INTERRUPT_IN = pif[1].pin_s[3:0];

    always_ff @(posedge MCLK) begin
        t2_prev_r <= pif[1].pin_s[`PFC_P1_T2_CLEAR:`PFC_P1_T2_EVENT];
        if (SRST) begin
            t2_event_r <= 1'b0;
            t2_clear_r <= 1'b0;
        end else begin
            t2_event_r <= pif[1].pin_s[`PFC_P1_T2_EVENT] & ~t2_prev_r[0]
                & latch_r[1][`PFC_P1_T2_EVENT];
            t2_clear_r <= pif[1].pin_s[`PFC_P1_T2_CLEAR] & ~t2_prev_r[1]
                & latch_r[1][`PFC_P1_T2_CLEAR];
        end
    end
    assign TIMER2_EVENT = t2_event_r;
    assign TIMER2_CLEAR = t2_clear_r;

    // ==========================================
    // port 5 and single-bit pin synchronisers
    always_ff @(posedge MCLK) begin
        p5_s1_r <= P5_I;
        p5_s2_r <= p5_s1_r;
        misc_s1_r <= {EXTERNAL_ACCESS_SELECT, CAN_RECEIVE_NEGATIVE, CAN_RECEIVE_POSITIVE,
            CONVERSION_START_PIN};
        misc_s2_r <= misc_s1_r;
    end
    assign ADC_CHANNEL_IN = p5_s2_r;
    assign conversion_start_pin_s = misc_s2_r[0];
    assign rxp_s = misc_s2_r[1];
    assign rxn_s = misc_s2_r[2];

    // ==========================================
    // conversion start
    always_ff @(posedge MCLK) begin
        // edge history runs through reset, so a pin held high gives no false edge
        conversion_start_pin_prev_r <= conversion_start_pin_s;
        if (SRST) begin
            adc_start_r <= 1'b0;
        end else begin
            adc_start_r <= (conversion_start_pin_s & ~conversion_start_pin_prev_r) | ADC_SW_START;
        end
    end
    assign ADC_START = adc_start_r;

    // ==========================================
    // reset pin as output
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rst_state_r <= pfc_pkg::PFC_RST_IDLE;
            rst_cnt_r <= '0;
        end else begin
            case (rst_state_r)
                pfc_pkg::PFC_RST_IDLE: begin
                    if (WDT_OVERFLOW | CAN_WAKEUP) begin
                        rst_state_r <= pfc_pkg::PFC_RST_DRIVE;
                        rst_cnt_r <= ($bits(rst_cnt_r))'(RST_PULSE_CYC - 1);
                    end
                end
                pfc_pkg::PFC_RST_DRIVE: begin
                    if (rst_cnt_r == '0) begin
                        rst_state_r <= pfc_pkg::PFC_RST_IDLE;
                    end else begin
                        rst_cnt_r <= rst_cnt_r - 1'b1;
                    end
                end
                default: rst_state_r <= pfc_pkg::PFC_RST_IDLE;
            endcase
        end
    end
    assign RST_PIN_O = 1'b1;
    assign RST_PIN_OE = (rst_state_r == pfc_pkg::PFC_RST_DRIVE);

    // ==========================================
    // address latch strobe cadence
    assign ale_slot = (ale_cnt_r == '0);
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ale_cnt_r <= '0;
            skip_r <= 1'b0;
            ale_r <= 1'b0;
        end else begin
            if (ale_cnt_r == ($bits(ale_cnt_r))'(ALE_PERIOD - 1)) begin
                ale_cnt_r <= '0;
            end else begin
                ale_cnt_r <= ale_cnt_r + 1'b1;
            end
            // a request in the slot itself is served by that same slot
            ale_r <= ale_slot & ~skip_r & ~XDATA_ACCESS;
            if (ale_slot) begin
                skip_r <= 1'b0;
            end else if (XDATA_ACCESS) begin
                skip_r <= 1'b1;
            end
        end
    end
    assign ALE = ale_r;

    // ==========================================
    // external access select and program fetch
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ea_latched_r <= misc_s2_r[3];
        end
    end

    assign fetch_ext_nxt = ~ea_latched_r | (FETCH_ADDR > `PFC_INT_ROM_TOP);
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            fetch_ext_r <= 1'b0;
            program_store_strobe_n_r <= 1'b1;
        end else begin
            fetch_ext_r <= fetch_ext_nxt;
            program_store_strobe_n_r <= ~(FETCH_REQ & fetch_ext_nxt);
        end
    end
    assign FETCH_EXTERNAL = fetch_ext_r;
    assign PROGRAM_STORE_STROBE_N = program_store_strobe_n_r;

    // ==========================================
    // CAN control bits, reference pin and half-supply source
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ref_out_r <= 1'b1;
            can_reset_r <= 1'b1;
        end else if (CAN_CTRL_WR) begin
            // bit low selects the internal source and output direction
            ref_out_r <= ~CAN_CTRL_WDATA[`PFC_CR_REF_DIR];
            can_reset_r <= CAN_CTRL_WDATA[`PFC_CR_CAN_RESET];
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            src_en_r <= 1'b1;
        end else begin
            src_en_r <= ref_out_r & ~(can_reset_r & POWER_DOWN);
        end
    end
    assign REF_PIN_OE = ref_out_r & src_en_r;
    assign REF_SOURCE_EN = src_en_r;
    assign CAN_IN_RESET = can_reset_r;

    // ==========================================
    // receive comparator decode; equal levels keep the last bit
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rx_r <= 1'b1;
        end else if (rxp_s & ~rxn_s) begin
            rx_r <= 1'b1;
        end else if (~rxp_s & rxn_s) begin
            rx_r <= 1'b0;
        end
    end
    assign CAN_RX_BIT = rx_r;
endmodule

// File: pfc_ext_mem.sv
// far-side model: external data memory on the multiplexed bus and the CAN line pair
`timescale 1ns/1ns
module pfc_ext_mem (
    input wire logic clk,
    input wire logic ale,
    input wire logic p0_en,
    input wire logic [7:0] p0_lvl,
    input wire logic [7:0] p2_lvl,
    input wire logic rd_n,
    input wire logic bus_dom,
    output logic [7:0] p0_drv,
    output logic can_pos,
    output logic can_neg
);
    logic [15:0] addr_r = 16'h0000;
    // ========================================
    // bus side
    initial p0_drv = 8'h00;
    always @(posedge clk) begin
        // the address is only taken while the device drives the whole low byte
        if (ale && p0_en) begin
            addr_r <= {p2_lvl, p0_lvl};
        end
        // released lines carry no stale value, so show a changing pattern
        p0_drv <= !rd_n ? (addr_r[7:0] ^ addr_r[15:8] ^ 8'h5A) : ~p0_drv;
    end
    // ========================================
    // line pair
    assign can_pos = !bus_dom;
    assign can_neg = bus_dom;
endmodule

// File: pfc_top_checker.sv
// concurrent checks on the pin function control top ports
`timescale 1ns/1ns
module pfc_top_checker #(
    parameter int RST_PULSE_CYC = 24
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [4:0] SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] P4_O,
    input wire logic [7:0] P4_OE,
    input wire logic [7:0] P4_PU,
    input wire logic [5:0] COMPARE_SETRESET_OUT,
    input wire logic [1:0] COMPARE_TOGGLE_OUT,
    input wire logic CONVERSION_START_PIN,
    input wire logic ADC_SW_START,
    input wire logic ADC_START,
    input wire logic WDT_OVERFLOW,
    input wire logic CAN_WAKEUP,
    input wire logic RST_PIN_O,
    input wire logic RST_PIN_OE,
    input wire logic XDATA_ACCESS,
    input wire logic ALE,
    input wire logic EXTERNAL_ACCESS_SELECT,
    input wire logic [15:0] FETCH_ADDR,
    input wire logic FETCH_REQ,
    input wire logic FETCH_EXTERNAL,
    input wire logic CAN_CTRL_WR,
    input wire logic [7:0] CAN_CTRL_WDATA,
    input wire logic POWER_DOWN,
    input wire logic REF_PIN_OE,
    input wire logic REF_SOURCE_EN,
    input wire logic CAN_RECEIVE_POSITIVE,
    input wire logic CAN_RECEIVE_NEGATIVE,
    input wire logic CAN_RX_BIT,
    input wire logic CAN_IN_RESET
);
    logic ea_q;
    logic dir_q;
    logic [7:0] lat4_q;
    int rst_cnt;
    // ========================================
    // shadow state
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ea_q <= EXTERNAL_ACCESS_SELECT;
            dir_q <= 1'b0;
            lat4_q <= 8'hFF;
            rst_cnt <= 0;
        end else begin
            dir_q <= CAN_CTRL_WR ? CAN_CTRL_WDATA[5] : dir_q;
            lat4_q <= SFR_WR[4] ? SFR_WDATA : lat4_q;
            rst_cnt <= RST_PIN_OE ? rst_cnt + 1 : 0;
        end
    end
    // ========================================
    // properties
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    a_ale_gap: assert property (ALE |=> !ALE [*5])
        else $error("strobe pulses closer than six");
    a_ale_period: assert property ((ALE && !XDATA_ACCESS) ##1 !XDATA_ACCESS [*6] |-> ALE)
        else $error("strobe slot missing");
    a_rst_start: assert property ((WDT_OVERFLOW || CAN_WAKEUP) && !RST_PIN_OE |=> RST_PIN_OE)
        else $error("reset pulse not started");
    a_rst_len: assert property ($fell(RST_PIN_OE) |-> rst_cnt == RST_PULSE_CYC)
        else $error("reset pulse length wrong");
    a_rst_level: assert property (RST_PIN_OE |-> RST_PIN_O && rst_cnt < RST_PULSE_CYC)
        else $error("reset pulse too long or wrong level");
    a_adc_sw: assert property (ADC_SW_START |=> ADC_START)
        else $error("software start lost");
    a_adc_pin: assert property ($rose(CONVERSION_START_PIN) |-> ##3 ADC_START)
        else $error("pin start lost");
    a_fetch_map: assert property (FETCH_REQ |=>
        FETCH_EXTERNAL == (!ea_q || $past(FETCH_ADDR) > 16'h7FFF))
        else $error("fetch source wrong");
    a_can_rst: assert property (CAN_CTRL_WR |=> CAN_IN_RESET == $past(CAN_CTRL_WDATA[0]))
        else $error("can reset bit not taken");
    a_ref_off: assert property (POWER_DOWN && CAN_IN_RESET |=> !REF_SOURCE_EN)
        else $error("reference source left on");
    a_ref_dir: assert property (REF_PIN_OE == (!dir_q && REF_SOURCE_EN))
        else $error("reference direction wrong");
    a_rx_decode: assert property (CAN_RECEIVE_POSITIVE != CAN_RECEIVE_NEGATIVE |->
        ##3 CAN_RX_BIT == $past(CAN_RECEIVE_POSITIVE, 3))
        else $error("receive bit wrong");
    a_p4_route: assert property (!$past(SRST) |->
        P4_O == ($past(lat4_q) & $past({COMPARE_TOGGLE_OUT, COMPARE_SETRESET_OUT})))
        else $error("port 4 routing wrong");
    a_p4_quasi: assert property (!$past(SRST) |-> P4_OE == ~P4_O && P4_PU == P4_O)
        else $error("port 4 drive wrong");
endmodule

// File: pfc_top_tb.sv
// self-checking bench for the pin function control block
`timescale 1ns/1ns
module pfc_top_tb;
    localparam int RPC = 4;
    logic MCLK, SRST, CONVERSION_START_PIN, ADC_SW_START, WDT_OVERFLOW, CAN_WAKEUP;
    logic XDATA_ACCESS, EXTERNAL_ACCESS_SELECT, FETCH_REQ, CAN_CTRL_WR, POWER_DOWN;
    logic CAN_RECEIVE_POSITIVE, CAN_RECEIVE_NEGATIVE, CAN_TRANSMIT_OUT_A, CAN_TRANSMIT_OUT_B;
    logic SERIAL_TX_OUT, XDATA_WRITE_STROBE_N, XDATA_READ_STROBE_N, XBUS_ACTIVE, bus_dom;
    logic XBUS_LOW_DRIVE, XBUS_ADDR_PHASE, ADC_START, RST_PIN_O, RST_PIN_OE, ALE;
    logic FETCH_EXTERNAL, PROGRAM_STORE_STROBE_N, REF_PIN_OE, REF_SOURCE_EN, CAN_RX_BIT;
    logic CAN_IN_RESET, TIMER2_EVENT, TIMER2_CLEAR, SERIAL_RX_IN, EXTERNAL_INTERRUPT_ZERO;
    logic EXTERNAL_INTERRUPT_ONE, TIMER0_COUNT_INPUT, TIMER1_COUNT_INPUT;
    logic [7:0] P0_I, P0_O, P0_OE, P1_I, P1_O, P1_OE, P1_PU, P2_I, P2_O, P2_OE, P2_PU;
    logic [7:0] P3_I, P3_O, P3_OE, P3_PU, P4_I, P4_O, P4_OE, P4_PU, P5_I, SFR_WDATA;
    logic [7:0] PORT_RD_DATA, ADC_CHANNEL_IN, CAN_CTRL_WDATA, XBUS_WDATA, p0_drv;
    logic [7:0] e1, e2, e3, e4;
    logic [4:0] SFR_WR;
    logic [2:0] PORT_RD_SEL;
    logic [15:0] FETCH_ADDR, XBUS_ADDR;
    logic [5:0] COMPARE_SETRESET_OUT;
    logic [3:0] CAPTURE_INPUT, EXTRA_INTERRUPT_IN;
    logic [1:0] COMPARE_TOGGLE_OUT;
    int err_total, checked, n;
    // ========================================
    // design, far side and pin levels
    pfc_top #(.ALE_PERIOD(6), .RST_PULSE_CYC(RPC)) u_pfc_top (.*);
    pfc_ext_mem u_pfc_ext_mem (.clk(MCLK), .ale(ALE), .p0_en(&P0_OE), .p0_lvl(P0_I),
        .p2_lvl(P2_I), .rd_n(P3_I[7]), .bus_dom(bus_dom), .p0_drv(p0_drv),
        .can_pos(CAN_RECEIVE_POSITIVE), .can_neg(CAN_RECEIVE_NEGATIVE));
    assign P0_I = (P0_OE & P0_O) | (~P0_OE & p0_drv);
    assign P1_I = (P1_OE & P1_O) | (~P1_OE & e1);
    assign P2_I = (P2_OE & P2_O) | (~P2_OE & e2);
    assign P3_I = (P3_OE & P3_O) | (~P3_OE & e3);
    assign P4_I = (P4_OE & P4_O) | (~P4_OE & e4);
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    // ========================================
    // tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge MCLK);
    endtask
    task automatic wr(input int p, input logic [7:0] d);
        SFR_WR = 5'h01 << p;
        SFR_WDATA = d;
        cyc(1);
        SFR_WR = 5'h00;
    endtask
    task automatic ctl(input logic [7:0] d);
        CAN_CTRL_WR = 1'b1;
        CAN_CTRL_WDATA = d;
        cyc(1);
        CAN_CTRL_WR = 1'b0;
        cyc(1);
    endtask
    task automatic fetch(input logic [15:0] a, input logic x);
        FETCH_ADDR = a;
        FETCH_REQ = 1'b1;
        cyc(1);
        chk("fetch", {x, ~x}, {FETCH_EXTERNAL, PROGRAM_STORE_STROBE_N});
    endtask
    task automatic rst(input logic ea);
        SRST = 1'b1;
        EXTERNAL_ACCESS_SELECT = ea;
        cyc(4);
        SRST = 1'b0;
        cyc(1);
        EXTERNAL_ACCESS_SELECT = ~ea;
        cyc(2);
    endtask
    // ========================================
    // sequence
    initial begin
        {SRST, CONVERSION_START_PIN, ADC_SW_START, WDT_OVERFLOW, CAN_WAKEUP} = '0;
        {XDATA_ACCESS, FETCH_REQ, CAN_CTRL_WR, POWER_DOWN, CAN_TRANSMIT_OUT_A} = '0;
        {CAN_TRANSMIT_OUT_B, XBUS_ACTIVE, XBUS_LOW_DRIVE, XBUS_ADDR_PHASE, bus_dom} = '0;
        {SERIAL_TX_OUT, XDATA_WRITE_STROBE_N, XDATA_READ_STROBE_N} = 3'b111;
        {SFR_WR, SFR_WDATA, PORT_RD_SEL, FETCH_ADDR, XBUS_ADDR, XBUS_WDATA} = '0;
        {CAN_CTRL_WDATA, COMPARE_SETRESET_OUT, COMPARE_TOGGLE_OUT, P5_I} = '0;
        {e1, e2, e3, e4} = '1;
        err_total = 0;
        checked = 0;
        rst(1'b1);
        chk("ref_oe", 1, REF_PIN_OE);
        chk("ref_src", 1, REF_SOURCE_EN);
        chk("p1_oe", 8'h00, P1_OE);
        chk("p1_pu", 8'h3F, P1_PU);
        fetch(16'h7FFF, 1'b0);
        fetch(16'h8000, 1'b1);
        n = 0;
        while (ALE !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        // second window carries one external data access mid-gap
        for (int i = 0; i < 2; i++) begin
            n = 0;
            for (int k = 1; k <= 60; k++) begin
                XDATA_ACCESS = (i == 1 && k == 3);
                cyc(1);
                n += ALE;
            end
            chk("ale_cnt", 16'(10 - i), 16'(n));
        end
        ADC_SW_START = 1'b1;
        cyc(1);
        ADC_SW_START = 1'b0;
        chk("adc_sw", 1, ADC_START);
        CONVERSION_START_PIN = 1'b1;
        cyc(3);
        chk("adc_pin", 1, ADC_START);
        cyc(1);
        chk("adc_once", 0, ADC_START);
        for (int i = 0; i < 2; i++) begin
            {WDT_OVERFLOW, CAN_WAKEUP} = i ? 2'b01 : 2'b10;
            cyc(1);
            {WDT_OVERFLOW, CAN_WAKEUP} = 2'b00;
            n = 0;
            while (RST_PIN_OE === 1'b1 && n < 50) begin
                n++;
                cyc(1);
            end
            chk("rst_len", RPC, 16'(n));
        end
        ctl(8'h21);
        chk("ref_in", 0, REF_PIN_OE);
        {CAN_TRANSMIT_OUT_B, CAN_TRANSMIT_OUT_A} = 2'b10;
        POWER_DOWN = 1'b1;
        ctl(8'h00);
        cyc(1);
        chk("ref_out", 1, REF_PIN_OE);
        chk("ctx", 4'hE, {P1_OE[7:6], P1_O[7:6]});
        ctl(8'h01);
        chk("ref_pd", 0, {REF_SOURCE_EN, REF_PIN_OE});
        chk("ctx_off", 0, P1_OE[7:6]);
        POWER_DOWN = 1'b0;
        for (int i = 0; i < 2; i++) begin
            bus_dom = ~i[0];
            cyc(3);
            chk("rx", {15'h0, i[0]}, {15'h0, CAN_RX_BIT});
        end
        COMPARE_SETRESET_OUT = 6'h2A;
        COMPARE_TOGGLE_OUT = 2'h1;
        cyc(2);
        chk("p4", 8'h6A, P4_O);
        wr(4, 8'h0F);
        cyc(1);
        chk("p4_lat", 8'h0A, P4_O);
        chk("p4_drv", 16'hF50A, {P4_OE, P4_PU});
        e1 = 8'hC5;
        cyc(4);
        chk("cap", 4'h5, CAPTURE_INPUT);
        chk("xint", 4'h5, EXTRA_INTERRUPT_IN);
        for (int i = 0; i < 2; i++) begin
            e1[4+i] = 1'b1;
            n = 0;
            repeat (6) begin
                cyc(1);
                n += i ? TIMER2_CLEAR : TIMER2_EVENT;
            end
            chk("t2", 1, 16'(n));
        end
        e3 = 8'hF5;
        SERIAL_TX_OUT = 1'b0;
        XDATA_WRITE_STROBE_N = 1'b0;
        cyc(4);
        chk("p3_in", 5'h1B, {TIMER1_COUNT_INPUT, TIMER0_COUNT_INPUT,
            EXTERNAL_INTERRUPT_ONE, EXTERNAL_INTERRUPT_ZERO, SERIAL_RX_IN});
        chk("p3_oe", 8'h42, P3_OE);
        {SERIAL_TX_OUT, XDATA_WRITE_STROBE_N} = 2'b11;
        // data phase first so the far side keeps the address taken last
        XBUS_ADDR = 16'h1234;
        XBUS_WDATA = 8'hA5;
        {XBUS_ACTIVE, XBUS_LOW_DRIVE} = 2'b11;
        cyc(2);
        chk("p0d", 16'hFFA5, {P0_OE, P0_O});
        XBUS_ADDR_PHASE = 1'b1;
        cyc(8);
        chk("p2", 16'hFF12, {P2_OE, P2_O});
        chk("p0a", 16'hFF34, {P0_OE, P0_O});
        {XBUS_LOW_DRIVE, XBUS_ADDR_PHASE, XDATA_READ_STROBE_N} = 3'b000;
        cyc(6);
        chk("p0rd", 8'h12 ^ 8'h34 ^ 8'h5A, PORT_RD_DATA);
        {XBUS_ACTIVE, XDATA_READ_STROBE_N} = 2'b01;
        wr(2, 8'h0F);
        e2 = 8'hAA;
        PORT_RD_SEL = 3'h2;
        cyc(5);
        chk("p2_rd", 16'h0F0A, {P2_PU, PORT_RD_DATA});
        P5_I = 8'h96;
        PORT_RD_SEL = 3'h5;
        cyc(5);
        chk("p5", 16'h9696, {ADC_CHANNEL_IN, PORT_RD_DATA});
        rst(1'b0);
        fetch(16'h0000, 1'b1);
        wrap_up();
    end
    // the sequence needs well under a thousand cycles; ten thousand means a hang
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule
bind pfc_top pfc_top_checker #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_pfc_top_checker (.*);
